/* File: src/mpe_params.svh */
/*
  Register indices, control bit positions, reset values and counts for the
  multimode pulse_modulator edge generator. Included by the package.
*/
`ifndef MPE_PARAMS_SVH
`define MPE_PARAMS_SVH
`define MPE_NREG 25
`define MPE_R_CTRL 5'h00
`define MPE_R_PERIOD 5'h01
`define MPE_R_EV1 5'h02
`define MPE_R_EV2 5'h03
`define MPE_R_EV3 5'h04
`define MPE_R_EV4 5'h05
`define MPE_R_CADJA 5'h06
`define MPE_R_CADJB 5'h07
`define MPE_R_ASOFF 5'h08
`define MPE_R_PHASE 5'h09
`define MPE_R_ST1 5'h0a
`define MPE_R_ST2 5'h0b
`define MPE_R_BLAB 5'h0c
`define MPE_R_BLAE 5'h0d
`define MPE_R_BLBB 5'h0e
`define MPE_R_BLBE 5'h0f
`define MPE_R_VIN 5'h10
`define MPE_R_VOUT 5'h11
`define MPE_R_SRSTEP 5'h12
`define MPE_R_LOUP 5'h13
`define MPE_R_LODN 5'h14
`define MPE_R_HIUP 5'h15
`define MPE_R_HIDN 5'h16
`define MPE_R_CFGMID 5'h17
`define MPE_R_CFGHI 5'h18
`define MPE_R_CNT 5'h19
`define MPE_R_STAT 5'h1a
`define MPE_R_SRON 5'h1b
`define MPE_R_IDEAL 5'h1c
`define MPE_B_PHSEL 3
`define MPE_B_ASHALF 4
`define MPE_B_AUTO 5
`define MPE_B_SREN 6
`define MPE_PERIOD_RST 16'h00ff
`define MPE_DIV_LEN 6'h20
`endif

/* File: src/mpe_pkg.sv */
/*
  Types of the multimode pulse_modulator edge generator: modes and the state
  record. Assumes mpe_params.svh is on the include path.
*/
`include "mpe_params.svh"
package mpe_pkg;
  typedef enum logic [2:0] {
    MPE_NORMAL = 3'b000,
    MPE_MULTI = 3'b001,
    MPE_RESON = 3'b010,
    MPE_TRI = 3'b011,
    MPE_LEAD = 3'b100
  } mpe_mode_t;
  typedef struct packed {
    logic [`MPE_NREG-1:0][15:0] regs;
    logic [15:0] cnt;
    logic [15:0] period;
    mpe_mode_t mode;
    logic [1:0] lvl;
    logic [15:0] ar;
    logic [15:0] af;
    logic [15:0] br;
    logic [15:0] bf;
    logic [15:0] as;
    logic [15:0] ph;
    logic aen;
    logic asen;
    logic oa;
    logic ob;
    logic bla;
    logic blb;
    logic st1;
    logic st2;
    logic asp;
    logic php;
    logic [15:0] rdata;
    logic [15:0] sr_on;
    logic [15:0] ideal;
    logic [5:0] dcnt;
    logic [31:0] dnum;
    logic [31:0] dq;
    logic [16:0] drem;
  } mpe_state_t;
endpackage : mpe_pkg

/* File: src/mpe_pwm.sv */
/*
  Edge placement for one pulse_modulator channel pair A and B with register
  port, automatic mode selection, sync FET ramp and diode_emulation_ontime.
  Assumes filter duty and period inputs are synchronous to i_clk.
*/
// Summary of operation
// - Period counter counts 0 to period_limit, wraps to zero, repeats.
// - A signal changes when the counter equals its target count.
// - Normal: A rises at Event1, falls at Event1+duty+adjust A.
// - Normal: B rises at A fall plus Event3-Event2, falls at Event4.
// - Adaptive sample at Event1 plus offset plus duty or half duty, minus duty in leading.
// - Normal mode ignores adjust B.
// - Sample triggers and blanking windows come straight from registers.
// - Phase trigger selectable between phase register and filter duty.
// - Multi: A as normal; B rises Event3, falls Event3+duty+adjust B.
// - Multi: Event2 and Event4 affect no edge.
// - Multi: B may wrap the period boundary; A is clamped inside it.
// - Resonant: both on for duty minus mean dead time, period from filter.
// - Resonant: only A rise is fixed; other edges follow filter.
// - Triangular: A silent; B centred on half period with adjusts.
// - Triangular: no adaptive sample trigger.
// - Leading: A falls Event1, rises Event1-duty+adjust A.
// - Leading: B rises Event4, falls at A rise minus Event2-Event3.
// - Sync FET on-time zero until nominal, then ramps per period.
// - Ideal on-time is duty times (vin-vout) over vout.
// - Mode changes happen in hardware without firmware action.
// - Auto mode picks base, mid or high configuration by filter duty.
// - Thresholds form hysteresis pairs between configuration levels.
`timescale 1ns/10ps
module mpe_pwm (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_nrst,
  // Register port.
  input wire logic [4:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  // Filter and supply status.
  input wire logic [15:0] i_filt_duty,
  input wire logic [15:0] i_filt_period,
  input wire logic i_vout_nominal,
  // Timing outputs.
  output logic o_pwm_a,
  output logic o_pwm_b,
  output logic o_blank_a,
  output logic o_blank_b,
  output logic o_samp1,
  output logic o_samp2,
  output logic o_asamp,
  output logic o_phase_trig,
  output logic [15:0] o_sr_ontime
);
  mpe_pkg::mpe_state_t s;
  mpe_pkg::mpe_state_t n;
  mpe_pkg::mpe_mode_t md;
  logic [15:0] c;
  logic [15:0] d;
  logic [15:0] np;
  logic [16:0] t17;
  logic [16:0] rem;
  logic [15:0] on;
  logic [1:0] nl;
  logic fin;

  assign o_rdata = s.rdata;
  assign o_pwm_a = s.oa;
  assign o_pwm_b = s.ob;
  assign o_blank_a = s.bla;
  assign o_blank_b = s.blb;
  assign o_samp1 = s.st1;
  assign o_samp2 = s.st2;
  assign o_asamp = s.asp;
  assign o_phase_trig = s.php;
  assign o_sr_ontime = s.sr_on;

  always_comb begin
    n = s;
    c = s.regs[`MPE_R_CTRL];
    d = i_filt_duty;
    fin = (s.cnt == s.period);
    nl = s.lvl;
    md = s.mode;
    np = s.regs[`MPE_R_PERIOD];
    t17 = 17'h0;
    rem = 17'h0;
    on = 16'h0;
    n.st1 = 1'b0;
    n.st2 = 1'b0;
    n.asp = 1'b0;
    n.php = 1'b0;
    n.rdata = 16'h0;
    if (fin) begin
      n.cnt = 16'h0;
    end else begin
      n.cnt = s.cnt + 16'h1;
    end
    if (s.cnt == s.ar) begin
      n.oa = s.aen;
    end
    if (s.cnt == s.af || !s.aen) begin
      n.oa = 1'b0;
    end
    if (s.cnt == s.br) begin
      n.ob = 1'b1;
    end
    if (s.cnt == s.bf) begin
      n.ob = 1'b0;
    end
    n.st1 = (s.cnt == s.regs[`MPE_R_ST1]);
    n.st2 = (s.cnt == s.regs[`MPE_R_ST2]);
    if (s.cnt == s.regs[`MPE_R_BLAB]) begin
      n.bla = 1'b1;
    end
    if (s.cnt == s.regs[`MPE_R_BLAE]) begin
      n.bla = 1'b0;
    end
    if (s.cnt == s.regs[`MPE_R_BLBB]) begin
      n.blb = 1'b1;
    end
    if (s.cnt == s.regs[`MPE_R_BLBE]) begin
      n.blb = 1'b0;
    end
    n.asp = s.asen && (s.cnt == s.as);
    n.php = (s.cnt == s.ph);
    // Serial divide, one quotient bit per clock.
    if (s.dcnt != 6'h0) begin
      rem = {s.drem[15:0], s.dnum[31]};
      n.dnum = {s.dnum[30:0], 1'b0};
      if (rem >= {1'b0, s.regs[`MPE_R_VOUT]}) begin
        n.drem = rem - {1'b0, s.regs[`MPE_R_VOUT]};
        n.dq = {s.dq[30:0], 1'b1};
      end else begin
        n.drem = rem;
        n.dq = {s.dq[30:0], 1'b0};
      end
      n.dcnt = s.dcnt - 6'h1;
      if (s.dcnt == 6'h1) begin
        n.ideal = (n.dq[31:16] != 16'h0) ? 16'hffff : n.dq[15:0];
      end
    end
    // Period start: every edge, adaptive sample and phase target for the next period is taken at once.
    if (fin) begin
      if (!c[`MPE_B_AUTO]) begin
        nl = 2'h0;
      end else begin
        case (s.lvl)
          2'h0: begin
            if (d > s.regs[`MPE_R_LOUP]) begin
              nl = 2'h1;
            end
          end
          2'h1: begin
            if (d > s.regs[`MPE_R_HIUP]) begin
              nl = 2'h2;
            end else if (d < s.regs[`MPE_R_LODN]) begin
              nl = 2'h0;
            end
          end
          default: begin
            if (d < s.regs[`MPE_R_HIDN]) begin
              nl = 2'h1;
            end
          end
        endcase
      end
      n.lvl = nl;
      // Mode taken from the selected set with no firmware step.
      if (nl == 2'h1) begin
        md = mpe_pkg::mpe_mode_t'(s.regs[`MPE_R_CFGMID][2:0]);
      end else if (nl == 2'h2) begin
        md = mpe_pkg::mpe_mode_t'(s.regs[`MPE_R_CFGHI][2:0]);
      end else begin
        md = mpe_pkg::mpe_mode_t'(c[2:0]);
      end
      // Resonant period comes from the filter.
      if (md == mpe_pkg::MPE_RESON) begin
        np = i_filt_period;
      end
      n.period = np;
      n.mode = md;
      n.aen = 1'b1;
      n.asen = 1'b1;
      // A rise and fall, shared by normal and multi.
      n.ar = s.regs[`MPE_R_EV1];
      n.af = s.regs[`MPE_R_EV1] + d + s.regs[`MPE_R_CADJA];
      // Adaptive sample, full or half duty.
      n.as = s.regs[`MPE_R_EV1] + s.regs[`MPE_R_ASOFF]
        + (c[`MPE_B_ASHALF] ? {1'b0, d[15:1]} : d);
      case (md)
        mpe_pkg::MPE_MULTI: begin
          // A clamped to the period, B wraps past it.
          t17 = {1'b0, n.af};
          if (t17 > {1'b0, np}) begin
            n.af = np;
          end
          // B from Event3 and adjust B.
          n.br = s.regs[`MPE_R_EV3];
          t17 = {1'b0, s.regs[`MPE_R_EV3]} + {1'b0, d}
            + {1'b0, s.regs[`MPE_R_CADJB]};
          if (t17 > {1'b0, np}) begin
            t17 = t17 - {1'b0, np} - 17'h1;
          end
          n.bf = t17[15:0];
        end
        mpe_pkg::MPE_RESON: begin
          // Event2 and Event4 hold the two dead times.
          t17 = {1'b0, s.regs[`MPE_R_EV2]} + {1'b0, s.regs[`MPE_R_EV4]};
          on = d - t17[16:1];
          n.af = s.regs[`MPE_R_EV1] + on;
          n.br = n.af + s.regs[`MPE_R_EV2];
          n.bf = n.br + on;
        end
        mpe_pkg::MPE_TRI: begin
          n.aen = 1'b0;
          n.asen = 1'b0;
          n.br = {1'b0, np[15:1]} - {1'b0, d[15:1]} + s.regs[`MPE_R_CADJA];
          n.bf = {1'b0, np[15:1]} + {1'b0, d[15:1]} + s.regs[`MPE_R_CADJB];
        end
        mpe_pkg::MPE_LEAD: begin
          n.af = s.regs[`MPE_R_EV1];
          n.ar = s.regs[`MPE_R_EV1] - d + s.regs[`MPE_R_CADJA];
          n.as = s.regs[`MPE_R_EV1] + s.regs[`MPE_R_ASOFF]
            - (c[`MPE_B_ASHALF] ? {1'b0, d[15:1]} : d);
          // B keeps a fixed gap before A rise.
          n.br = s.regs[`MPE_R_EV4];
          n.bf = n.ar - (s.regs[`MPE_R_EV2] - s.regs[`MPE_R_EV3]);
        end
        default: begin
          // B follows A fall by Event3-Event2.
          n.br = n.af + (s.regs[`MPE_R_EV3] - s.regs[`MPE_R_EV2]);
          n.bf = s.regs[`MPE_R_EV4];
        end
      endcase
      n.ph = c[`MPE_B_PHSEL] ? d : s.regs[`MPE_R_PHASE];
      // Start a new on-time calculation each period.
      if (s.regs[`MPE_R_VIN] > s.regs[`MPE_R_VOUT]) begin
        n.dnum = {16'h0, d} * {16'h0, s.regs[`MPE_R_VIN] - s.regs[`MPE_R_VOUT]};
      end else begin
        n.dnum = 32'h0;
      end
      n.dq = 32'h0;
      n.drem = 17'h0;
      n.dcnt = `MPE_DIV_LEN;
      // Ramp rises at most one step per period toward the ideal value; a lower ideal value is taken at once.
      if (!c[`MPE_B_SREN] || !i_vout_nominal) begin
        n.sr_on = 16'h0;
      end else begin
        t17 = {1'b0, s.sr_on} + {1'b0, s.regs[`MPE_R_SRSTEP]};
        n.sr_on = (t17 >= {1'b0, s.ideal}) ? s.ideal : t17[15:0];
      end
    end
    // Register writes; writes above the table are dropped.
    if (i_wr && i_addr < `MPE_R_CNT) begin
      n.regs[i_addr] = i_wdata;
    end
    if (i_rd) begin
      if (i_addr < `MPE_R_CNT) begin
        n.rdata = s.regs[i_addr];
      end else if (i_addr == `MPE_R_CNT) begin
        n.rdata = s.cnt;
      end else if (i_addr == `MPE_R_STAT) begin
        n.rdata = {11'h0, s.lvl, s.mode};
      end else if (i_addr == `MPE_R_SRON) begin
        n.rdata = s.sr_on;
      end else if (i_addr == `MPE_R_IDEAL) begin
        n.rdata = s.ideal;
      end else begin
        n.rdata = 16'h0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s <= '0;
      s.regs[`MPE_R_PERIOD] <= `MPE_PERIOD_RST;
      // Latched period starts at the register value so count zero is never doubled.
      s.period <= `MPE_PERIOD_RST;
    end else begin
      s <= n;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  property p_wrap;
    s.cnt == s.period |=> s.cnt == 16'h0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap");

  property p_inc;
    s.cnt != s.period |=> s.cnt == $past(s.cnt) + 16'h1;
  endproperty
  a_inc: assert property (p_inc) else $error("counter did not step");

  property p_arise;
    s.aen && s.cnt == s.ar && s.cnt != s.af |=> o_pwm_a ##1 $stable(s.ar);
  endproperty
  a_arise: assert property (p_arise) else $error("A missed rise");

  property p_bfall;
    s.cnt == s.bf |=> !o_pwm_b;
  endproperty
  a_bfall: assert property (p_bfall) else $error("B missed fall");

  property p_st1;
    s.cnt == s.regs[`MPE_R_ST1] |=> o_samp1 ##1 !o_samp1;
  endproperty
  a_st1: assert property (p_st1) else $error("sample 1 wrong");

  property p_tri;
    s.mode == mpe_pkg::MPE_TRI && !s.aen |=> !o_pwm_a && !o_asamp;
  endproperty
  a_tri: assert property (p_tri) else $error("A active in triangular");

  property p_sroff;
    fin && !i_vout_nominal |=> o_sr_ontime == 16'h0;
  endproperty
  a_sroff: assert property (p_sroff) else $error("sync FET on early");

  property p_hyst;
    fin && s.lvl == 2'h1 && c[`MPE_B_AUTO] && d >= s.regs[`MPE_R_LODN]
      && d <= s.regs[`MPE_R_HIUP] |=> s.lvl == 2'h1;
  endproperty
  a_hyst: assert property (p_hyst) else $error("level left band");

  property p_latch;
    !fin |=> $stable(s.af) && $stable(s.bf) && $stable(s.period);
  endproperty
  a_latch: assert property (p_latch) else $error("target moved mid period");

  property p_rdcnt;
    i_rd && i_addr == `MPE_R_CNT |=> o_rdata == $past(s.cnt);
  endproperty
  a_rdcnt: assert property (p_rdcnt) else $error("counter read wrong");

  property p_afall;
    s.cnt == s.af |=> !o_pwm_a;
  endproperty
  a_afall: assert property (p_afall) else $error("A missed fall");

  property p_aclamp;
    s.mode == mpe_pkg::MPE_MULTI |-> s.af <= s.period;
  endproperty
  a_aclamp: assert property (p_aclamp) else $error("A crosses period end");

  property p_st2;
    s.cnt == s.regs[`MPE_R_ST2] |=> o_samp2;
  endproperty
  a_st2: assert property (p_st2) else $error("sample 2 missed");

  property p_phase;
    s.cnt == s.ph |=> o_phase_trig;
  endproperty
  a_phase: assert property (p_phase) else $error("phase trigger missed");
endmodule : mpe_pwm

/* File: tb/mpe_stage_model.sv */
/*
  Power stage model for the edge generator bench: gate drivers and output filter.
  Assumes output A is the primary switch and that i_run releases the soft start.
*/
`timescale 1ns/10ps
module mpe_stage_model #(
  parameter int NOM_PULSES = 2
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_nrst,
  // Gate drive and start control.
  input wire logic i_pwm_a,
  input wire logic i_run,
  // Output status.
  output logic o_vout_nominal
);
  logic a_ff;
  logic [3:0] n_ff;
  // Nominal after pulses.
  // The output needs a few primary pulses to charge, so the ramp hold-off can be seen.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      a_ff <= 1'b0;
      n_ff <= 4'h0;
    end else begin
      a_ff <= i_pwm_a;
      if (!i_run) begin
        n_ff <= 4'h0;
      end else if (i_pwm_a && !a_ff && n_ff != 4'hf) begin
        n_ff <= n_ff + 4'h1;
      end
    end
  end
  assign o_vout_nominal = (n_ff >= NOM_PULSES[3:0]);
endmodule : mpe_stage_model

/* File: tb/test_multimode_pwm_edge_generator.sv */
/*
  Self-checking bench for the pulse_modulator edge generator.
  Assumes sample trigger 1 at count 0 marks the start of every period.
*/
`timescale 1ns/10ps
`include "mpe_params.svh"
module test_multimode_pwm_edge_generator;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic [4:0] i_addr = 5'h00;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [15:0] i_filt_duty = 16'h0000;
  logic [15:0] i_filt_period = 16'h0014;
  logic run = 1'b0;
  logic nominal;
  logic [15:0] o_rdata;
  logic [15:0] o_sr_ontime;
  logic o_pwm_a, o_pwm_b, o_blank_a, o_blank_b, o_samp1, o_samp2, o_asamp, o_phase_trig;
  int n_errors = 0;
  int n_compared = 0;
  int lim = 20;
  logic [63:0] va, vb, vs, vp, vx, vy, vz;
  logic [15:0] rv;
  always #20 i_clk = ~i_clk;
  mpe_pwm dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_filt_duty(i_filt_duty),
    .i_filt_period(i_filt_period), .i_vout_nominal(nominal), .o_pwm_a(o_pwm_a),
    .o_pwm_b(o_pwm_b), .o_blank_a(o_blank_a), .o_blank_b(o_blank_b), .o_samp1(o_samp1),
    .o_samp2(o_samp2), .o_asamp(o_asamp), .o_phase_trig(o_phase_trig),
    .o_sr_ontime(o_sr_ontime));
  mpe_stage_model part (.i_clk(i_clk), .i_nrst(i_nrst), .i_pwm_a(o_pwm_a), .i_run(run),
    .o_vout_nominal(nominal));
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    d = o_rdata;
  endtask : rd
  // Waits for the start of a period; a missing period ends the run.
  task automatic wsamp;
    int i;
    @(negedge i_clk);
    for (i = 0; i < 400 && o_samp1 !== 1'b1; i++) @(negedge i_clk);
    if (o_samp1 !== 1'b1) begin
      check(64'(o_samp1), 64'h1);
      complete_run();
    end
  endtask : wsamp
  function automatic logic [63:0] win(input int r, input int f);
    logic [63:0] v;
    v = '0;
    for (int k = 0; k <= lim; k++) v[k] = (r <= f) ? (k >= r && k < f) : (k >= r || k < f);
    return v;
  endfunction : win
  // Records one period; sample k shows the outputs decided at count k.
  task automatic measure;
    wsamp();
    for (int k = 0; k <= lim; k++) begin
      if (k > 0) @(negedge i_clk);
      {va[k], vb[k], vs[k], vp[k]} = {o_pwm_a, o_pwm_b, o_asamp, o_phase_trig};
      {vx[k], vy[k], vz[k]} = {o_blank_a, o_blank_b, o_samp2};
    end
    check(vx, win(1, 3));
    check(vy, win(12, 14));
    check(vz, 64'h1 << 10);
    // The next sample must open a new period, which pins the period length.
    @(negedge i_clk);
    check(64'(o_samp1), 64'h1);
  endtask : measure
  task automatic setm(input logic [15:0] c, e1, e2, e3, e4, dt);
    wr(`MPE_R_CTRL, c);
    wr(`MPE_R_EV1, e1);
    wr(`MPE_R_EV2, e2);
    wr(`MPE_R_EV3, e3);
    wr(`MPE_R_EV4, e4);
    i_filt_duty <= dt;
    repeat (3) wsamp();
    measure();
  endtask : setm
  task automatic t_reset;
    rd(`MPE_R_PERIOD, rv);
    check(64'(rv), 64'h00ff);
    rd(`MPE_R_CTRL, rv);
    check(64'(rv), 64'h0);
    wr(`MPE_R_STAT, 16'hffff);
    rd(`MPE_R_STAT, rv);
    check(64'(rv), 64'h0);
    rd(5'h1d, rv);
    check(64'(rv), 64'h0);
    wr(`MPE_R_PERIOD, 16'h0014);
    wr(`MPE_R_ST1, 16'h0000);
    wr(`MPE_R_ST2, 16'h000a);
    wr(`MPE_R_BLAB, 16'h0001);
    wr(`MPE_R_BLAE, 16'h0003);
    wr(`MPE_R_BLBB, 16'h000c);
    wr(`MPE_R_BLBE, 16'h000e);
    wr(`MPE_R_CADJA, 16'h0001);
    wr(`MPE_R_CADJB, 16'h0004);
    wr(`MPE_R_ASOFF, 16'h0001);
    wr(`MPE_R_PHASE, 16'h0003);
    $display("register test done");
  endtask : t_reset
  task automatic t_count;
    int prev;
    int top;
    repeat (2) wsamp();
    rd(`MPE_R_CNT, rv);
    prev = int'(rv);
    top = prev;
    for (int i = 0; i < 12; i++) begin
      rd(`MPE_R_CNT, rv);
      check(64'(rv), 64'((prev + 2) % (lim + 1)));
      prev = int'(rv);
      if (prev > top) top = prev;
    end
    check(64'(top), 64'(lim));
    $display("counter test done");
  endtask : t_count
  task automatic t_normal;
    setm(16'h0000, 16'h0002, 16'h0005, 16'h0007, 16'h0010, 16'h0004);
    check(va, win(2, 7));
    check(vb, win(9, 16));
    check(vs, 64'h1 << 7);
    check(vp, 64'h1 << 3);
    setm(16'h0018, 16'h0002, 16'h0005, 16'h0007, 16'h0010, 16'h0004);
    check(vs, 64'h1 << 5);
    check(vp, 64'h1 << 4);
    $display("normal mode test done");
  endtask : t_normal
  task automatic t_multi;
    for (int i = 0; i < 2; i++) begin
      setm(16'h0001, 16'h0002, i ? 16'h0009 : 16'h0005, 16'h000e, i ? 16'h0003 : 16'h0010,
        16'h0004);
      check(va, win(2, 7));
      check(vb, win(14, 1));
      check(vs, 64'h1 << 7);
    end
    $display("multi mode test done");
  endtask : t_multi
  task automatic t_other;
    // Period register differs from the filter period, so only the filter can give 20.
    wr(`MPE_R_PERIOD, 16'h001e);
    setm(16'h0002, 16'h0002, 16'h0002, 16'h0000, 16'h0004, 16'h000a);
    check(va, win(2, 9));
    check(vb, win(11, 18));
    wr(`MPE_R_PERIOD, 16'h0014);
    setm(16'h0003, 16'h0002, 16'h0005, 16'h0007, 16'h0010, 16'h0004);
    check(va, 64'h0);
    check(vb, win(9, 16));
    check(vs, 64'h0);
    setm(16'h0004, 16'h000c, 16'h0007, 16'h0005, 16'h0010, 16'h0004);
    check(va, win(9, 12));
    check(vb, win(16, 7));
    check(vs, 64'h1 << 9);
    $display("resonant, triangular and leading test done");
  endtask : t_other
  task automatic t_syncfet;
    logic [15:0] first;
    first = 16'h0000;
    wr(`MPE_R_PERIOD, 16'h0028);
    lim = 40;
    wr(`MPE_R_VIN, 16'h000c);
    wr(`MPE_R_VOUT, 16'h0004);
    wr(`MPE_R_SRSTEP, 16'h0003);
    setm(16'h0040, 16'h000c, 16'h0005, 16'h0007, 16'h0010, 16'h0004);
    repeat (2) wsamp();
    check(64'(o_sr_ontime), 64'h0);
    rd(`MPE_R_IDEAL, rv);
    check(64'(rv), 64'h8);
    @(posedge i_clk);
    run <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      wsamp();
      if (first === 16'h0000) first = o_sr_ontime;
    end
    check(64'(first), 64'h3);
    check(64'(o_sr_ontime), 64'h8);
    $display("sync fet test done");
  endtask : t_syncfet
  task automatic t_auto;
    logic [15:0] duty [5] = '{16'h0019, 16'h000f, 16'h002d, 16'h0023, 16'h0005};
    logic [15:0] stat [5] = '{16'h0009, 16'h0009, 16'h0014, 16'h0014, 16'h0000};
    wr(`MPE_R_PERIOD, 16'h003c);
    wr(`MPE_R_LOUP, 16'h0014);
    wr(`MPE_R_LODN, 16'h000a);
    wr(`MPE_R_HIUP, 16'h0028);
    wr(`MPE_R_HIDN, 16'h001e);
    wr(`MPE_R_CFGMID, 16'h0001);
    wr(`MPE_R_CFGHI, 16'h0004);
    wr(`MPE_R_CTRL, 16'h0020);
    for (int i = 0; i < 5; i++) begin
      @(posedge i_clk);
      i_filt_duty <= duty[i];
      repeat (4) wsamp();
      rd(`MPE_R_STAT, rv);
      check(64'(rv), 64'(stat[i]));
    end
    $display("auto mode test done");
  endtask : t_auto
  initial begin
    repeat (20) @(posedge i_clk);
    i_nrst <= 1'b1;
    t_reset();
    t_count();
    t_normal();
    t_multi();
    t_other();
    t_syncfet();
    t_auto();
    complete_run();
  end
endmodule : test_multimode_pwm_edge_generator
